// ===== design/uart_status_cfg.svh
// Register map, field positions, reset values and timing counts of the serial status and control block
// Operation
// - A set break request makes the next transmission a break frame, and hardware clears the bit when it ends.
// - With transmit enable set the port drives its transmit pin and sends characters.
// - Clearing transmit enable aborts transmission, empties the transmit buffer and hands the pin back to I/O.
// - The transmit buffer full flag reads one exactly when no transmit buffer entry is free.
// - The shifter empty flag reads one only when shifter and transmit buffer are both empty, and resets to one.
// - The shifter empty flag reads zero while a character shifts out or waits in the transmit buffer.
// - Receive mode 11 raises the receive event when a transfer fills the four-entry receive buffer.
// - Receive mode 10 raises the receive event when a transfer leaves three characters in the buffer.
// - Receive mode 0x raises the receive event on every character moved into the receive buffer.
// - Transmit inversion changes the line only while the infrared encoder is on.
`ifndef UART_STATUS_CFG_SVH
`define UART_STATUS_CFG_SVH

// ----------------------------------------
// Offsets
// ----------------------------------------
`define STATUS_CONTROL_OFS 8'h00
`define TX_DATA_OFS 8'h04
`define RX_DATA_OFS 8'h08
`define PORT_MODE_OFS 8'h0C
`define IRQ_STATUS_OFS 8'h10
`define IRQ_MASK_OFS 8'h14

// ----------------------------------------
// Fields of serial_status_control and of the port mode register
// ----------------------------------------
`define TX_MODE_HI_BIT 15
`define TX_INVERT_BIT 14
`define TX_MODE_LO_BIT 13
`define BREAK_BIT 11
`define TX_ENABLE_BIT 10
`define TX_FULL_BIT 9
`define SHIFTER_EMPTY_BIT 8
`define RX_MODE_HI_BIT 7
`define RX_MODE_LO_BIT 6
`define RX_IDLE_BIT 4
`define FRAME_ERR_BIT 2
`define OVERRUN_BIT 1
`define RX_AVAIL_BIT 0
`define IR_ON_BIT 0
`define PORT_EN_BIT 1

// ----------------------------------------
// Reset values and counts
// ----------------------------------------
`define CTRL_RESET 1'b0
`define IRQ_RESET 4'h0
`define BIT_CYCLES_DEFAULT 16
`define FRAME_BITS 4'hA
`define BREAK_BITS 4'hE
`define QUEUE_DEPTH 4

`endif

// ===== design/uart_status_pkg.sv
// Types shared by the serial status and control block
package uart_status_pkg;
	typedef enum logic [1:0] {
		TX_IDLE = 2'b00,
		TX_SHIFT = 2'b01
	} tx_state_t;
	typedef enum logic [1:0] {
		RX_IDLE = 2'b00,
		RX_START = 2'b01,
		RX_DATA = 2'b11,
		RX_STOP = 2'b10
	} rx_state_t;
endpackage

// ===== design/char_queue.sv
// Small character queue held in flip-flops
`timescale 1ns/1ps
module char_queue #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4,
	parameter int CW = 3
) (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic flush_i,
	input wire logic push_i,
	input wire logic [WIDTH-1:0] data_i,
	input wire logic pop_i,
	output logic [WIDTH-1:0] data_o,
	output logic [CW-1:0] count_o,
	output logic full_o,
	output logic empty_o
);
	localparam int PW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [PW-1:0] wr_r;
	logic [PW-1:0] rd_r;
	logic do_push;
	logic do_pop;

	assign full_o = count_o == CW'(DEPTH);
	assign empty_o = count_o == '0;
	assign do_push = push_i && !full_o;
	assign do_pop = pop_i && !empty_o;
	assign data_o = mem_r[rd_r];

	always_ff @(posedge clk_i) begin
		if (do_push) begin
			mem_r[wr_r] <= data_i;
		end
	end

	// Pointers wrap naturally because the depth is a power of two
	always_ff @(posedge clk_i) begin
		if (sys_rst_i || flush_i) begin
			wr_r <= '0;
			rd_r <= '0;
			count_o <= '0;
		end else begin
			wr_r <= wr_r + PW'(do_push);
			rd_r <= rd_r + PW'(do_pop);
			count_o <= count_o + CW'(do_push) - CW'(do_pop);
		end
	end
endmodule // char_queue

// ===== design/rx_shifter_unit.sv
// Receive shifter: start detection, mid-bit sampling, eight data bits and one stop bit
`timescale 1ns/1ps
module rx_shifter_unit #(
	parameter int BIT_CYCLES = 16
) (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic enable_i,
	input wire logic line_i,
	output logic valid_o,
	output logic [7:0] data_o,
	output logic frame_err_o,
	output logic idle_o
);
	uart_status_pkg::rx_state_t state_r;
	logic [15:0] cyc_r;
	logic [3:0] bit_r;
	logic tick;

	assign tick = cyc_r == 16'(BIT_CYCLES - 1);
	assign idle_o = state_r == uart_status_pkg::RX_IDLE;

	always_ff @(posedge clk_i) begin
		if (sys_rst_i || !enable_i) begin
			state_r <= uart_status_pkg::RX_IDLE;
			cyc_r <= '0;
			bit_r <= '0;
			valid_o <= 1'b0;
			data_o <= '0;
			frame_err_o <= 1'b0;
		end else begin
			valid_o <= 1'b0;
			cyc_r <= tick ? '0 : cyc_r + 16'h0001;
			case (state_r)
				uart_status_pkg::RX_IDLE: begin
					cyc_r <= '0;
					if (!line_i) begin
						state_r <= uart_status_pkg::RX_START;
					end
				end
				// Half a bit in, recheck so a glitch is not taken for a start bit
				uart_status_pkg::RX_START: begin
					if (cyc_r == 16'(BIT_CYCLES / 2)) begin
						cyc_r <= '0;
						bit_r <= '0;
						state_r <= line_i ? uart_status_pkg::RX_IDLE : uart_status_pkg::RX_DATA;
					end
				end
				uart_status_pkg::RX_DATA: begin
					if (tick) begin
						data_o <= {line_i, data_o[7:1]};
						bit_r <= bit_r + 4'h1;
						if (bit_r == 4'h7) begin
							state_r <= uart_status_pkg::RX_STOP;
						end
					end
				end
				default: begin
					if (tick) begin
						valid_o <= 1'b1;
						frame_err_o <= !line_i;
						state_r <= uart_status_pkg::RX_IDLE;
					end
				end
			endcase
		end
	end
endmodule // rx_shifter_unit

// ===== design/uart_status_ctrl.sv
// Serial port status and control: register port, transmit shifter, pin handover, receive events
`timescale 1ns/1ps
`include "uart_status_cfg.svh"
module uart_status_ctrl #(
	parameter int BIT_CYCLES = `BIT_CYCLES_DEFAULT,
	parameter int DEPTH = `QUEUE_DEPTH
) (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic [7:0] addr_i,
	input wire logic [15:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [15:0] rdata_o,
	input wire logic rx_pin_i,
	input wire logic gpio_out_i,
	input wire logic gpio_oe_n_i,
	output logic tx_pin_o,
	output logic tx_pin_oe_n_o,
	output logic irq_o
);
	localparam int BREAK_WAIT = 14 * BIT_CYCLES + 4;

	// ----------------------------------------
	// Control state
	// ----------------------------------------
	logic [1:0] tx_mode_r, rx_mode_r;
	logic tx_invert_r, break_r, tx_en_r, overrun_r, ir_on_r, port_en_r, is_break_r;
	logic [3:0] ist_r, mask_r;
	uart_status_pkg::tx_state_t tx_state_r;
	logic [13:0] frame_r;
	logic [3:0] bits_left_r;
	logic [15:0] baud_r;

	logic wr_stat, wr_txd, rd_rxd, wr_ist, tx_push, rx_push, rx_pop, tx_load;
	logic [7:0] tx_head, rx_head, rx_char;
	logic [2:0] tx_count, rx_count;
	logic tx_full, tx_empty, rx_full, rx_empty, rx_valid, rx_ferr, rx_idle;
	logic bit_tick, tx_finish, tx_line, shifter_empty, rx_ev, tx_ev;
	logic [3:0] ev;

	// ----------------------------------------
	// Address decode
	// ----------------------------------------
	assign wr_stat = wr_i && addr_i == `STATUS_CONTROL_OFS;
	assign wr_txd = wr_i && addr_i == `TX_DATA_OFS;
	assign rd_rxd = rd_i && addr_i == `RX_DATA_OFS;
	assign wr_ist = wr_i && addr_i == `IRQ_STATUS_OFS;

	// ----------------------------------------
	// Queues and receiver
	// ----------------------------------------
	assign tx_push = wr_txd && tx_en_r;
	assign rx_push = rx_valid && !rx_full;
	assign rx_pop = rd_rxd && !rx_empty;

	char_queue #(
		.WIDTH(8),
		.DEPTH(DEPTH),
		.CW(3)
	) tx_queue (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.flush_i(!tx_en_r),
		.push_i(tx_push),
		.data_i(wdata_i[7:0]),
		.pop_i(tx_load),
		.data_o(tx_head),
		.count_o(tx_count),
		.full_o(tx_full),
		.empty_o(tx_empty)
	);

	char_queue #(
		.WIDTH(8),
		.DEPTH(DEPTH),
		.CW(3)
	) rx_queue (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.flush_i(!port_en_r),
		.push_i(rx_push),
		.data_i(rx_char),
		.pop_i(rx_pop),
		.data_o(rx_head),
		.count_o(rx_count),
		.full_o(rx_full),
		.empty_o(rx_empty)
	);

	rx_shifter_unit #(
		.BIT_CYCLES(BIT_CYCLES)
	) rx_unit (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.enable_i(port_en_r),
		.line_i(rx_pin_i),
		.valid_o(rx_valid),
		.data_o(rx_char),
		.frame_err_o(rx_ferr),
		.idle_o(rx_idle)
	);

	// ----------------------------------------
	// Control register writes
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			tx_mode_r <= {2{`CTRL_RESET}};
			tx_invert_r <= `CTRL_RESET;
			tx_en_r <= `CTRL_RESET;
			rx_mode_r <= {2{`CTRL_RESET}};
		end else if (wr_stat) begin
			tx_mode_r <= {wdata_i[`TX_MODE_HI_BIT], wdata_i[`TX_MODE_LO_BIT]};
			tx_invert_r <= wdata_i[`TX_INVERT_BIT];
			tx_en_r <= wdata_i[`TX_ENABLE_BIT];
			rx_mode_r <= {wdata_i[`RX_MODE_HI_BIT], wdata_i[`RX_MODE_LO_BIT]};
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			ir_on_r <= `CTRL_RESET;
			port_en_r <= `CTRL_RESET;
		end else if (wr_i && addr_i == `PORT_MODE_OFS) begin
			ir_on_r <= wdata_i[`IR_ON_BIT];
			port_en_r <= wdata_i[`PORT_EN_BIT];
		end
	end

	// Software may set the break bit; hardware clears it when the break frame ends
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			break_r <= `CTRL_RESET;
		end else if (wr_stat) begin
			break_r <= wdata_i[`BREAK_BIT] && wdata_i[`TX_ENABLE_BIT];
		end else if (!tx_en_r || (tx_finish && is_break_r)) begin
			break_r <= 1'b0;
		end
	end

	// A new overrun in the clearing cycle wins over the software clear
	always_ff @(posedge clk_i) begin
		if (sys_rst_i || !port_en_r) begin
			overrun_r <= `CTRL_RESET;
		end else if (rx_valid && rx_full) begin
			overrun_r <= 1'b1;
		end else if (wr_stat && !wdata_i[`OVERRUN_BIT]) begin
			overrun_r <= 1'b0;
		end
	end

	// ----------------------------------------
	// Transmit shifter
	// ----------------------------------------
	assign tx_load = tx_state_r == uart_status_pkg::TX_IDLE && !tx_empty && tx_en_r;
	assign bit_tick = baud_r == 16'(BIT_CYCLES - 1);
	assign tx_finish = tx_state_r == uart_status_pkg::TX_SHIFT && bit_tick && bits_left_r == 4'h1;
	assign tx_line = tx_state_r == uart_status_pkg::TX_SHIFT ? frame_r[0] : 1'b1;
	assign shifter_empty = tx_empty && tx_state_r == uart_status_pkg::TX_IDLE;

	// A break frame takes the queued character as a dummy and sends start, twelve zeros, stop
	always_ff @(posedge clk_i) begin
		if (sys_rst_i || !tx_en_r) begin
			tx_state_r <= uart_status_pkg::TX_IDLE;
			frame_r <= '1;
			bits_left_r <= '0;
			baud_r <= '0;
			is_break_r <= 1'b0;
		end else begin
			case (tx_state_r)
				uart_status_pkg::TX_IDLE: begin
					baud_r <= '0;
					if (tx_load) begin
						tx_state_r <= uart_status_pkg::TX_SHIFT;
						is_break_r <= break_r;
						if (break_r) begin
							frame_r <= {1'b1, 13'h0000};
							bits_left_r <= `BREAK_BITS;
						end else begin
							frame_r <= {4'hF, 1'b1, tx_head, 1'b0};
							bits_left_r <= `FRAME_BITS;
						end
					end
				end
				default: begin
					baud_r <= bit_tick ? '0 : baud_r + 16'h0001;
					if (bit_tick) begin
						frame_r <= {1'b1, frame_r[13:1]};
						bits_left_r <= bits_left_r - 4'h1;
						if (bits_left_r == 4'h1) begin
							tx_state_r <= uart_status_pkg::TX_IDLE;
						end
					end
				end
			endcase
		end
	end

	// ----------------------------------------
	// Pin handover
	// ----------------------------------------
	// Registered so the pin never glitches while the owner changes
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			tx_pin_o <= 1'b1;
			tx_pin_oe_n_o <= 1'b1;
		end else if (tx_en_r) begin
			tx_pin_o <= tx_line ^ (tx_invert_r & ir_on_r);
			tx_pin_oe_n_o <= 1'b0;
		end else begin
			tx_pin_o <= gpio_out_i;
			tx_pin_oe_n_o <= gpio_oe_n_i;
		end
	end

	// ----------------------------------------
	// Events and interrupt
	// ----------------------------------------
	always_comb begin
		case (rx_mode_r)
			2'b11: rx_ev = rx_push && !rx_pop && rx_count == 3'h3;
			2'b10: rx_ev = rx_push && (rx_pop ? rx_count == 3'h3 : rx_count == 3'h2);
			default: rx_ev = rx_push;
		endcase
		case (tx_mode_r)
			2'b00: tx_ev = tx_load;
			2'b01: tx_ev = tx_finish && tx_empty;
			2'b10: tx_ev = tx_load && tx_count == 3'h1;
			default: tx_ev = 1'b0;
		endcase
	end

	assign ev = {tx_finish && is_break_r, rx_valid && rx_full, tx_ev, rx_ev};

	// Write one clears; a new event in the same cycle stays set
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			ist_r <= `IRQ_RESET;
		end else begin
			ist_r <= (ist_r & ~(wr_ist ? wdata_i[3:0] : 4'h0)) | ev;
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			mask_r <= `IRQ_RESET;
		end else if (wr_i && addr_i == `IRQ_MASK_OFS) begin
			mask_r <= wdata_i[3:0];
		end
	end

	assign irq_o = |(ist_r & mask_r);

	// ----------------------------------------
	// Read port
	// ----------------------------------------
	function automatic logic [15:0] status_word(input logic [1:0] txm, input logic inv, input logic brk,
		input logic en, input logic full, input logic sempty, input logic [1:0] rxm, input logic ridle,
		input logic ferr, input logic rx_overrun, input logic avail);
		logic [15:0] w;
		w = 16'h0000;
		w[`TX_MODE_HI_BIT] = txm[1];
		w[`TX_INVERT_BIT] = inv;
		w[`TX_MODE_LO_BIT] = txm[0];
		w[`BREAK_BIT] = brk;
		w[`TX_ENABLE_BIT] = en;
		w[`TX_FULL_BIT] = full;
		w[`SHIFTER_EMPTY_BIT] = sempty;
		w[`RX_MODE_HI_BIT] = rxm[1];
		w[`RX_MODE_LO_BIT] = rxm[0];
		w[`RX_IDLE_BIT] = ridle;
		w[`FRAME_ERR_BIT] = ferr;
		w[`OVERRUN_BIT] = rx_overrun;
		w[`RX_AVAIL_BIT] = avail;
		return w;
	endfunction

	always_ff @(posedge clk_i) begin
		if (sys_rst_i || !rd_i) begin
			rdata_o <= 16'h0000;
		end else if (addr_i == `STATUS_CONTROL_OFS) begin
			rdata_o <= status_word(tx_mode_r, tx_invert_r, break_r, tx_en_r, tx_full,
				shifter_empty, rx_mode_r, rx_idle, rx_ferr, overrun_r, !rx_empty);
		end else if (addr_i == `RX_DATA_OFS) begin
			rdata_o <= {8'h00, rx_head};
		end else if (addr_i == `PORT_MODE_OFS) begin
			rdata_o <= {14'h0000, port_en_r, ir_on_r};
		end else if (addr_i == `IRQ_STATUS_OFS) begin
			rdata_o <= {12'h000, ist_r};
		end else if (addr_i == `IRQ_MASK_OFS) begin
			rdata_o <= {12'h000, mask_r};
		end else begin
			rdata_o <= 16'h0000;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	property p_full_read;
		@(posedge clk_i) disable iff (sys_rst_i)
		rd_i && addr_i == `STATUS_CONTROL_OFS |=> rdata_o[`TX_FULL_BIT] == ($past(tx_count) == 3'(DEPTH));
	endproperty
	a_full_read: assert property (p_full_read) else $error("full flag wrong");

	property p_empty_after_reset;
		@(posedge clk_i) $fell(sys_rst_i) |-> shifter_empty;
	endproperty
	a_empty_after_reset: assert property (p_empty_after_reset) else $error("shifter empty not one");

	property p_busy_after_push;
		@(posedge clk_i) disable iff (sys_rst_i)
		tx_push && !tx_full |=> !shifter_empty;
	endproperty
	a_busy_after_push: assert property (p_busy_after_push) else $error("shifter empty while queued");

	property p_disable_flush;
		@(posedge clk_i) disable iff (sys_rst_i)
		$fell(tx_en_r) |=> tx_empty && tx_state_r == uart_status_pkg::TX_IDLE ##1 tx_pin_oe_n_o == $past(gpio_oe_n_i);
	endproperty
	a_disable_flush: assert property (p_disable_flush) else $error("disable did not abort");

	property p_drive_pin;
		@(posedge clk_i) disable iff (sys_rst_i)
		tx_en_r |=> !tx_pin_oe_n_o;
	endproperty
	a_drive_pin: assert property (p_drive_pin) else $error("pin not driven");

	property p_break_clears;
		@(posedge clk_i) disable iff (sys_rst_i)
		tx_load && break_r && !wr_stat |=> is_break_r ##[1:BREAK_WAIT] !break_r;
	endproperty
	a_break_clears: assert property (p_break_clears) else $error("break bit not cleared");

	property p_rx_full_event;
		@(posedge clk_i) disable iff (sys_rst_i)
		rx_push && !rx_pop && rx_mode_r == 2'b11 && rx_count == 3'h3 |=> ist_r[0] && rx_full;
	endproperty
	a_rx_full_event: assert property (p_rx_full_event) else $error("fill event missing");

	property p_rx_three_event;
		@(posedge clk_i) disable iff (sys_rst_i)
		rx_push && !rx_pop && rx_mode_r == 2'b10 && rx_count == 3'h2 |=> ist_r[0] && rx_count == 3'h3;
	endproperty
	a_rx_three_event: assert property (p_rx_three_event) else $error("three event missing");

	property p_rx_any_event;
		@(posedge clk_i) disable iff (sys_rst_i)
		rx_push && !rx_mode_r[1] |=> ist_r[0];
	endproperty
	a_rx_any_event: assert property (p_rx_any_event) else $error("char event missing");

	property p_no_invert;
		@(posedge clk_i) disable iff (sys_rst_i)
		tx_en_r && !ir_on_r |=> tx_pin_o == $past(tx_line);
	endproperty
	a_no_invert: assert property (p_no_invert) else $error("inversion without encoder");

	property p_overrun;
		@(posedge clk_i) disable iff (sys_rst_i)
		port_en_r && rx_valid && rx_full |=> overrun_r [*2];
	endproperty
	a_overrun: assert property (p_overrun) else $error("overrun not held");
endmodule // uart_status_ctrl

// ===== tb/serial_node.sv
// Remote serial node model: sends 8N1 frames and decodes frames and breaks from the line
`timescale 1ns/1ps
module serial_node #(
	parameter int BIT_CYCLES = 4
) (
	input wire logic clk_i,
	input wire logic line_i,
	output logic line_o
);
	logic [7:0] got_q[$];
	int low_q[$];
	logic [8:0] b;
	logic [9:0] frame;
	int n;
	// ----------------------------------------
	// Transmit side, line idles high
	// ----------------------------------------
	initial line_o = 1'b1;
	task automatic send(input logic [7:0] c);
		frame = {1'b1, c, 1'b0};
		@(posedge clk_i);
		for (int i = 0; i < 10; i++) begin
			line_o <= frame[i];
			repeat (BIT_CYCLES) @(posedge clk_i);
		end
	endtask
	// ----------------------------------------
	// Receive side
	// ----------------------------------------
	// A low stop bit is taken as a break; the low bit times are counted so the break length can be judged
	initial forever begin
		@(posedge clk_i);
		if (line_i === 1'b0) begin
			repeat (BIT_CYCLES / 2) @(posedge clk_i);
			for (int i = 0; i < 9; i++) begin
				repeat (BIT_CYCLES) @(posedge clk_i);
				b[i] = line_i;
			end
			if (b[8] === 1'b1) begin
				got_q.push_back(b[7:0]);
			end else begin
				n = 10;
				repeat (BIT_CYCLES) @(posedge clk_i);
				while (line_i === 1'b0 && n < 40) begin
					n++;
					repeat (BIT_CYCLES) @(posedge clk_i);
				end
				low_q.push_back(n);
			end
		end
	end
endmodule // serial_node

// ===== tb/test_uart_status_ctrl.sv
// Self-checking bench for the serial status and control block
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_mismatch++; $display("[ERR] t=%0t got=%h exp=%h", $time, g, e); end end
module test_uart_status_ctrl;
	localparam int BIT = 4;
	logic clk_i, sys_rst_i, wr_i, rd_i, gpio_out_i, gpio_oe_n_i, rx_pin_i, tx_pin_o, tx_pin_oe_n_o, irq_o;
	logic [7:0] addr_i;
	logic [15:0] wdata_i, rdata_o, v;
	logic tx_line;
	int thr[4] = '{1, 1, 3, 4};
	int n_mismatch = 0;
	int n_tests = 0;
	// Pull-up on the transmit wire while nobody drives it
	assign tx_line = tx_pin_oe_n_o ? 1'b1 : tx_pin_o;
	uart_status_ctrl #(.BIT_CYCLES(BIT), .DEPTH(4)) u_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .rx_pin_i(rx_pin_i), .gpio_out_i(gpio_out_i),
		.gpio_oe_n_i(gpio_oe_n_i), .tx_pin_o(tx_pin_o), .tx_pin_oe_n_o(tx_pin_oe_n_o), .irq_o(irq_o));
	serial_node #(.BIT_CYCLES(BIT)) u_node (.clk_i(clk_i), .line_i(tx_line), .line_o(rx_pin_i));
	initial begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end
	// ----------------------------------------
	// Register port tasks and bench helpers
	// ----------------------------------------
	task automatic drive(input logic w, input logic r, input logic [7:0] a, input logic [15:0] d);
		@(posedge clk_i);
		wr_i <= w;
		rd_i <= r;
		addr_i <= a;
		wdata_i <= d;
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		drive(1'b1, 1'b0, a, d);
		drive(1'b0, 1'b0, a, d);
	endtask
	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [15:0] d);
		drive(1'b0, 1'b1, a, 16'h0000);
		drive(1'b0, 1'b0, a, 16'h0000);
		#1;
		d = rdata_o;
	endtask
	task automatic wait_bit(input int b, input logic val);
		for (int k = 0; k < 100; k++) begin
			rd(8'h00, v);
			if (v[b] === val) break;
		end
	endtask
	task automatic settle();
		repeat (60) @(posedge clk_i);
		u_node.got_q.delete();
		u_node.low_q.delete();
	endtask
	task automatic report_and_stop();
		$display("mismatches=%0d tests=%0d", n_mismatch, n_tests);
		if (n_mismatch == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// ----------------------------------------
	// Watchdog
	// ----------------------------------------
	// Whole sequence needs well under 10k cycles, so 50k means a hang
	initial begin
		repeat (50000) @(posedge clk_i);
		n_mismatch++;
		report_and_stop();
	end
	// ----------------------------------------
	// Test sequence
	// ----------------------------------------
	initial begin
		sys_rst_i = 1'b1;
		wr_i = 1'b0;
		rd_i = 1'b0;
		addr_i = 8'h00;
		wdata_i = 16'h0000;
		gpio_out_i = 1'b0;
		gpio_oe_n_i = 1'b0;
		repeat (10) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		rd(8'h00, v);
		`CHK(v, 16'h0110)
		`CHK(tx_pin_o, 1'b0)
		`CHK(tx_pin_oe_n_o, 1'b0)
		rd(8'hFE, v);
		`CHK(v, 16'h0000)
		// Pins are handed to the port only after the line is parked high
		@(posedge clk_i);
		gpio_out_i <= 1'b1;
		gpio_oe_n_i <= 1'b1;
		settle();
		// Burst of six writes: shifter plus four entries, the sixth is refused
		wr(8'h00, 16'h0400);
		@(posedge clk_i);
		#1;
		`CHK(tx_pin_oe_n_o, 1'b0)
		`CHK(tx_pin_o, 1'b1)
		for (int i = 0; i < 6; i++) drive(1'b1, 1'b0, 8'h04, {8'h00, 8'hA0 + 8'(i)});
		drive(1'b0, 1'b0, 8'h00, 16'h0000);
		rd(8'h00, v);
		`CHK(v[9:8], 2'b10)
		wait_bit(9, 1'b0);
		`CHK(v[9:8], 2'b00)
		wait_bit(8, 1'b1);
		`CHK(v[9:8], 2'b01)
		repeat (2 * BIT) @(posedge clk_i);
		`CHK(u_node.got_q.size(), 5)
		for (int i = 0; i < 5; i++) `CHK(u_node.got_q[i], 8'hA0 + 8'(i))
		// Abort in mid-frame with a character still queued
		wr(8'h04, 16'h005A);
		wr(8'h04, 16'h005B);
		repeat (10) @(posedge clk_i);
		wr(8'h00, 16'h0000);
		repeat (2) @(posedge clk_i);
		#1;
		`CHK(tx_pin_oe_n_o, 1'b1)
		`CHK(tx_pin_o, 1'b1)
		rd(8'h00, v);
		`CHK(v[10:8], 3'b001)
		settle();
		// Break: thirteen low bit times, then the request bit clears itself
		wr(8'h00, 16'h0C00);
		wr(8'h04, 16'h0055);
		rd(8'h00, v);
		`CHK(v[11], 1'b1)
		wait_bit(11, 1'b0);
		`CHK(v[11], 1'b0)
		repeat (2 * BIT) @(posedge clk_i);
		`CHK(u_node.low_q.size(), 1)
		`CHK(u_node.low_q[0], 13)
		rd(8'h10, v);
		`CHK(v[3], 1'b1)
		`CHK(v[1], 1'b1)
		// Inversion is ignored with the encoder off and flips the idle line with it on
		wr(8'h10, 16'h000F);
		wr(8'h00, 16'h6400);
		wr(8'h04, 16'h00C3);
		wait_bit(8, 1'b1);
		repeat (2 * BIT) @(posedge clk_i);
		`CHK(u_node.got_q[0], 8'hC3)
		rd(8'h10, v);
		`CHK(v[1], 1'b1)
		wr(8'h0C, 16'h0001);
		repeat (3) @(posedge clk_i);
		#1;
		`CHK(tx_pin_o, 1'b0)
		wr(8'h0C, 16'h0000);
		wr(8'h00, 16'h0000);
		settle();
		// Receive event level for every mode, with events sticky until cleared
		wr(8'h14, 16'h0001);
		for (int m = 0; m < 4; m++) begin
			wr(8'h0C, 16'h0000);
			wr(8'h0C, 16'h0002);
			wr(8'h00, {8'h00, 2'(m), 6'h00});
			wr(8'h10, 16'h000F);
			for (int n = 1; n <= 4; n++) begin
				u_node.send(8'h30 + 8'(n));
				repeat (8) @(posedge clk_i);
				rd(8'h10, v);
				`CHK(v[0], (n >= thr[m]) ? 1'b1 : 1'b0)
				`CHK(irq_o, (n >= thr[m]) ? 1'b1 : 1'b0)
			end
		end
		// Fifth character into a full buffer is dropped and flags overrun
		u_node.send(8'h77);
		repeat (8) @(posedge clk_i);
		rd(8'h00, v);
		`CHK(v[1], 1'b1)
		wr(8'h14, 16'h0004);
		#1;
		`CHK(irq_o, 1'b1)
		wr(8'h14, 16'h0000);
		#1;
		`CHK(irq_o, 1'b0)
		wr(8'h10, 16'h0004);
		rd(8'h10, v);
		`CHK(v[2], 1'b0)
		rd(8'h08, v);
		`CHK(v[7:0], 8'h31)
		wr(8'h00, 16'h00C2);
		rd(8'h00, v);
		`CHK(v[1], 1'b1)
		wr(8'h00, 16'h00C0);
		rd(8'h00, v);
		`CHK(v[1], 1'b0)
		report_and_stop();
	end
endmodule // test_uart_status_ctrl
